// ===== src/bfp_regs.svh
/*
  register offsets, status field positions, reset values and timing figures
  of the battery fault priority controller.
  assumes a 125 MHz system clock; definitions only.
*/
`ifndef BFP_REGS_SVH
`define BFP_REGS_SVH

`define BFP_CTRL_OFS      8'h00
`define BFP_STAT_OFS      8'h04
`define BFP_CTRL_RST      1'h1

`define BFP_ST_OVC        0
`define BFP_ST_OVD        1
`define BFP_ST_OI         2
`define BFP_ST_SC         3
`define BFP_ST_EC         4
`define BFP_ST_SBY        5
`define BFP_ST_SHORT      6

`define BFP_CLK_NS        8
`define BFP_TICK_NS       1000
`define BFP_TICK_CYC      ((`BFP_TICK_NS + `BFP_CLK_NS - 1) / `BFP_CLK_NS)
`define BFP_SHORTEN_SHIFT 6

`define BFP_OVC_DET_US    1000000
`define BFP_OVC_REL_US    16000
`define BFP_OVD_DET_US    20000
`define BFP_OVD_REL_US    1000
`define BFP_OI_DET_US     10000
`define BFP_OI_REL_US     1000
`define BFP_EC_DET_US     1000
`define BFP_EC_REL_US     1000
`define BFP_SC_DLY_NS     300000

`endif

// ===== src/bfp_pkg.sv
/*
  types shared by the battery fault priority controller.
  assumes bfp_regs.svh for the numeric figures.
*/
package bfp_pkg;
  typedef logic [23:0] bfp_cnt_t;
  typedef enum logic [2:0] {
    BFP_OVC_DET,
    BFP_OVC_REL,
    BFP_OVD_DET,
    BFP_OVD_REL,
    BFP_OI_DET,
    BFP_OI_REL,
    BFP_EC_DET,
    BFP_EC_REL
  } bfp_dly_id_t;
endpackage

// ===== src/bfp_dly_if.sv
/*
  carrier between the controller and one qualified delay counter.
  assumes all signals live in the sys_clk domain.
*/
`timescale 1ns/100ps
interface bfp_dly_if;
  logic              qual;
  logic              tick;
  logic              shorten;
  bfp_pkg::bfp_cnt_t limit;
  logic              done;
  modport ctl (output qual, output tick, output shorten, output limit, input done);
  modport cnt (input qual, input tick, input shorten, input limit, output done);
endinterface

// ===== src/bfp_sync.sv
/*
  two flip-flop synchroniser for a bundle of asynchronous levels.
  assumes the inputs are slow comparator or pin levels.
*/
`timescale 1ns/100ps
module bfp_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ===== src/bfp_dly.sv
/*
  delay counter qualified by one condition; pulses done at terminal count.
  assumes qual, tick and shorten are synchronous to sys_clk.
*/
`timescale 1ns/100ps
`include "bfp_regs.svh"
module bfp_dly (
  input wire logic sys_clk,
  input wire logic arst_n,
  bfp_dly_if.cnt   d
);
  bfp_pkg::bfp_cnt_t cnt_reg;
  bfp_pkg::bfp_cnt_t short_lim;
  bfp_pkg::bfp_cnt_t lim;
  logic              done_reg;

  // a shortened limit never falls to zero, so the counter still terminates
  assign short_lim = d.limit >> `BFP_SHORTEN_SHIFT;
  assign lim = d.shorten ? ((short_lim == '0) ? 24'h000001 : short_lim)
                         : d.limit;
  assign d.done = done_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!d.qual) begin
        cnt_reg <= '0;
      end else if (d.tick) begin
        if (cnt_reg + 24'h000001 >= lim) begin
          cnt_reg  <= '0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 24'h000001;
        end
      end
    end
  end

  a_dly_restart:
    assert property (@(posedge sys_clk) disable iff (!arst_n)
      !d.qual |=> cnt_reg == '0 && !done_reg)
    else $error("delay counter kept counting after its condition dropped");
endmodule

// ===== src/bfp_ctrl.sv
/*
  state and priority logic of a two-cell battery protection controller:
  over-charge, over-discharge, over-current, short-circuit and excessive
  charger detection, overlap priority, standby and charger-minus pull paths.
  assumes comparator flags and the shorten pin arrive asynchronously and a
  plain register port on sys_clk.
*/
// Design decisions made here: the register addresses and the strobed register port.
// Contract
// - shorten pin high cuts every counter-timed delay.
// - shorten pin low or open gives full counter delays.
// - short-circuit delay ignores the shorten pin.
// - over-charge wins over over-discharge; over-discharge detection restarts afterwards.
// - over-discharge after over-charge: no standby, sense node pulled up.
// - over-charge and over-current run together; over-charge first abandons over-current.
// - over-current first pulls sense node down; over-charge first releases it.
// - over-discharge and over-current run together; over-discharge first abandons over-current.
// - short-circuit detection runs independently of all priority logic.
// - no excessive-charger detection during over-discharge, over-current, short-circuit.
// - excessive-charger delay starts only after discharge output returns high.
// - charge output goes low once the over-charge delay elapses.
// - over-discharge enters standby and pulls the sense node up.
// - over-current drives discharge low, pulls sense down, no standby.
`timescale 1ns/100ps
`include "bfp_regs.svh"
module bfp_ctrl #(
  parameter int OVC_DET_US = `BFP_OVC_DET_US,
  parameter int OVC_REL_US = `BFP_OVC_REL_US,
  parameter int OVD_DET_US = `BFP_OVD_DET_US,
  parameter int OVD_REL_US = `BFP_OVD_REL_US,
  parameter int OI_DET_US  = `BFP_OI_DET_US,
  parameter int OI_REL_US  = `BFP_OI_REL_US,
  parameter int EC_DET_US  = `BFP_EC_DET_US,
  parameter int EC_REL_US  = `BFP_EC_REL_US,
  parameter int SC_DLY_NS  = `BFP_SC_DLY_NS
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        ovc_det_cmp,
  input  wire logic        ovc_rel_cmp,
  input  wire logic        ovd_det_cmp,
  input  wire logic        ovd_rel_cmp,
  input  wire logic        oi_det_cmp,
  input  wire logic        oi_rel_cmp,
  input  wire logic        sc_det_cmp,
  input  wire logic        ec_det_cmp,
  input  wire logic        sby_rel_cmp,
  input  wire logic        test_shorten,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             chg_gate,
  output logic             dis_gate,
  output logic             vm_pull_up,
  output logic             vm_pull_dn,
  output logic             standby
);
  localparam int SC_CYC_I = (SC_DLY_NS + `BFP_CLK_NS - 1) / `BFP_CLK_NS;
  localparam int SC_CYC   = (SC_CYC_I < 1) ? 1 : SC_CYC_I;

  logic [9:0]        cmp_s;
  logic              ovc_s;
  logic              ovc_rel_s;
  logic              ovd_s;
  logic              ovd_rel_s;
  logic              oi_s;
  logic              oi_rel_s;
  logic              sc_s;
  logic              ec_s;
  logic              sby_rel_s;
  logic              shorten_s;
  logic [6:0]        tick_cnt_reg;
  logic              tick_reg;
  logic              det_en_reg;
  logic              ovc_state_reg;
  logic              ovd_state_reg;
  logic              oi_state_reg;
  logic              sc_state_reg;
  logic              ec_state_reg;
  logic              standby_reg;
  logic              chg_gate_reg;
  logic              dis_gate_reg;
  logic              pull_up_reg;
  logic              pull_dn_reg;
  logic [31:0]       rdata_reg;
  logic [7:0]        qual;
  logic [7:0]        done;
  bfp_pkg::bfp_cnt_t lim_arr [8];
  logic              sc_done;

  bfp_sync #(.W(10)) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       ({test_shorten, sby_rel_cmp, ec_det_cmp, sc_det_cmp, oi_rel_cmp,
                oi_det_cmp, ovd_rel_cmp, ovd_det_cmp, ovc_rel_cmp, ovc_det_cmp}),
    .q       (cmp_s)
  );

  assign ovc_s     = cmp_s[0];
  assign ovc_rel_s = cmp_s[1];
  assign ovd_s     = cmp_s[2];
  assign ovd_rel_s = cmp_s[3];
  assign oi_s      = cmp_s[4];
  assign oi_rel_s  = cmp_s[5];
  assign sc_s      = cmp_s[6];
  assign ec_s      = cmp_s[7];
  assign sby_rel_s = cmp_s[8];
  assign shorten_s = cmp_s[9];

  // one microsecond enable for the counter-timed delays
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == 7'(`BFP_TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 7'h01;
      tick_reg     <= 1'b0;
    end
  end

  // detection qualifiers: this is where the overlap priority lives
  always_comb begin
    qual = '0;
    qual[bfp_pkg::BFP_OVC_DET] = det_en_reg && ovc_s && !ovc_state_reg;
    qual[bfp_pkg::BFP_OVC_REL] = ovc_state_reg && ovc_rel_s;
    // over-discharge timing is held at zero while over-charge is being timed
    qual[bfp_pkg::BFP_OVD_DET] = det_en_reg && ovd_s && !ovd_state_reg
                                 && !qual[bfp_pkg::BFP_OVC_DET];
    // release needs the charger, i.e. standby already left
    qual[bfp_pkg::BFP_OVD_REL] = ovd_state_reg && !standby_reg && ovd_rel_s;
    qual[bfp_pkg::BFP_OI_DET]  = det_en_reg && oi_s && !oi_state_reg
                                 && !ovc_state_reg
                                 && !ovd_state_reg;
    qual[bfp_pkg::BFP_OI_REL]  = (oi_state_reg || sc_state_reg) && oi_rel_s;
    qual[bfp_pkg::BFP_EC_DET]  = det_en_reg && ec_s && !ec_state_reg
                                 && !ovd_state_reg && !oi_state_reg
                                 && !sc_state_reg
                                 && dis_gate_reg;
    qual[bfp_pkg::BFP_EC_REL]  = ec_state_reg && !ec_s;
  end

  assign lim_arr[0] = 24'(OVC_DET_US);
  assign lim_arr[1] = 24'(OVC_REL_US);
  assign lim_arr[2] = 24'(OVD_DET_US);
  assign lim_arr[3] = 24'(OVD_REL_US);
  assign lim_arr[4] = 24'(OI_DET_US);
  assign lim_arr[5] = 24'(OI_REL_US);
  assign lim_arr[6] = 24'(EC_DET_US);
  assign lim_arr[7] = 24'(EC_REL_US);

  bfp_dly_if dly_if [8] ();

  for (genvar i = 0; i < 8; i++) begin : g_dly
    assign dly_if[i].qual    = qual[i];
    assign dly_if[i].tick    = tick_reg;
    assign dly_if[i].shorten = shorten_s;
    assign dly_if[i].limit   = lim_arr[i];
    assign done[i]           = dly_if[i].done;
    bfp_dly u_dly (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .d       (dly_if[i].cnt)
    );
  end

  // short circuit is timed in raw clock cycles, never shortened
  bfp_dly_if sc_if ();
  assign sc_if.qual    = det_en_reg && sc_s && !sc_state_reg;
  assign sc_if.tick    = 1'b1;
  assign sc_if.shorten = 1'b0;
  assign sc_if.limit   = 24'(SC_CYC);
  assign sc_done       = sc_if.done;

  bfp_dly u_sc_dly (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       (sc_if.cnt)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovc_state_reg <= 1'b0;
    end else if (!det_en_reg) begin
      ovc_state_reg <= 1'b0;
    end else if (done[bfp_pkg::BFP_OVC_DET]) begin
      ovc_state_reg <= 1'b1;
    end else if (done[bfp_pkg::BFP_OVC_REL]) begin
      ovc_state_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovd_state_reg <= 1'b0;
      standby_reg   <= 1'b0;
    end else if (!det_en_reg) begin
      ovd_state_reg <= 1'b0;
      standby_reg   <= 1'b0;
    end else if (done[bfp_pkg::BFP_OVD_DET]) begin
      ovd_state_reg <= 1'b1;
      standby_reg   <= !ovc_state_reg;
    end else begin
      if (done[bfp_pkg::BFP_OVD_REL]) begin
        ovd_state_reg <= 1'b0;
      end
      if (standby_reg && sby_rel_s) begin
        standby_reg <= 1'b0;
      end
    end
  end

  // over-discharge abandons a pending over-current; an established one stays
  // set, but the sense node moves from the ground pull to the supply pull
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oi_state_reg <= 1'b0;
      sc_state_reg <= 1'b0;
    end else if (!det_en_reg) begin
      oi_state_reg <= 1'b0;
      sc_state_reg <= 1'b0;
    end else begin
      if (done[bfp_pkg::BFP_OI_DET]) begin
        oi_state_reg <= 1'b1;
      end else if (done[bfp_pkg::BFP_OI_REL]) begin
        oi_state_reg <= 1'b0;
      end
      if (sc_done) begin
        sc_state_reg <= 1'b1;
      end else if (done[bfp_pkg::BFP_OI_REL]) begin
        sc_state_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ec_state_reg <= 1'b0;
    end else if (!det_en_reg) begin
      ec_state_reg <= 1'b0;
    end else if (done[bfp_pkg::BFP_EC_DET]) begin
      ec_state_reg <= 1'b1;
    end else if (done[bfp_pkg::BFP_EC_REL]) begin
      ec_state_reg <= 1'b0;
    end
  end

  // gate and pull outputs, one cycle behind the states
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chg_gate_reg <= 1'b1;
      dis_gate_reg <= 1'b1;
      pull_up_reg  <= 1'b0;
      pull_dn_reg  <= 1'b0;
    end else begin
      chg_gate_reg <= !(ovc_state_reg || ec_state_reg);
      dis_gate_reg <= !(ovd_state_reg || oi_state_reg || sc_state_reg);
      pull_up_reg  <= ovd_state_reg;
      // over-current reached first keeps the ground pull even if over-charge
      // follows, since over-current timing is abandoned once over-charge holds
      pull_dn_reg  <= (oi_state_reg || sc_state_reg) && !ovd_state_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_en_reg <= `BFP_CTRL_RST;
    end else if (reg_wr && reg_addr == `BFP_CTRL_OFS) begin
      det_en_reg <= reg_wdata[0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else if (!reg_rd) begin
      rdata_reg <= '0;
    end else begin
      case (reg_addr)
        `BFP_CTRL_OFS: rdata_reg <= {31'h0, det_en_reg};
        `BFP_STAT_OFS: begin
          rdata_reg                <= '0;
          rdata_reg[`BFP_ST_OVC]   <= ovc_state_reg;
          rdata_reg[`BFP_ST_OVD]   <= ovd_state_reg;
          rdata_reg[`BFP_ST_OI]    <= oi_state_reg;
          rdata_reg[`BFP_ST_SC]    <= sc_state_reg;
          rdata_reg[`BFP_ST_EC]    <= ec_state_reg;
          rdata_reg[`BFP_ST_SBY]   <= standby_reg;
          rdata_reg[`BFP_ST_SHORT] <= shorten_s;
        end
        default: rdata_reg <= '0;
      endcase
    end
  end

  assign reg_rdata  = rdata_reg;
  assign chg_gate   = chg_gate_reg;
  assign dis_gate   = dis_gate_reg;
  assign vm_pull_up = pull_up_reg;
  assign vm_pull_dn = pull_dn_reg;
  assign standby    = standby_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_od_suspended:
    assert property (qual[bfp_pkg::BFP_OVC_DET] |-> !qual[bfp_pkg::BFP_OVD_DET])
    else $error("over-discharge timed while over-charge pending");

  a_ovc_no_sby:
    // standby is decided by the over-charge state of the edge that set
    // over-discharge, so look one cycle back in case over-charge just released
    assert property ($rose(ovd_state_reg) && $past(ovc_state_reg)
                     |-> !standby_reg ##1 pull_up_reg)
    else $error("standby entered after over-charge");

  a_oi_abandon:
    assert property (ovc_state_reg || ovd_state_reg |-> !qual[bfp_pkg::BFP_OI_DET])
    else $error("over-current timed after over-charge or over-discharge");

  a_pull_dn_oi:
    assert property (oi_state_reg && !ovd_state_reg |=> pull_dn_reg && !pull_up_reg)
    else $error("ground pull missing in over-current");

  a_od_sby_pull:
    assert property ($rose(ovd_state_reg) && !$past(ovc_state_reg) |-> standby_reg
                     ##1 pull_up_reg && !pull_dn_reg)
    else $error("over-discharge did not pull up into standby");

  a_sc_free:
    assert property (det_en_reg && sc_s && !sc_state_reg |-> sc_if.qual)
    else $error("short-circuit timing blocked");

  a_ec_blocked:
    assert property (ovd_state_reg || oi_state_reg || sc_state_reg
                     |-> !qual[bfp_pkg::BFP_EC_DET])
    else $error("excessive charger timed during a fault");

  a_ec_after_dis:
    assert property (!dis_gate_reg |-> !qual[bfp_pkg::BFP_EC_DET])
    else $error("excessive charger timed while discharge low");

  a_chg_low:
    assert property (done[bfp_pkg::BFP_OVC_DET] |=> ##1 !chg_gate_reg)
    else $error("charge output not low after over-charge delay");

  a_oi_outputs:
    assert property ($rose(oi_state_reg) |-> !standby_reg ##1 !dis_gate_reg)
    else $error("over-current outputs wrong");

  c_ovc_set: cover property ($rose(ovc_state_reg));
  c_ovd_sby: cover property ($rose(standby_reg));
  c_oi_then_od: cover property (oi_state_reg ##[1:1000] $rose(ovd_state_reg));
  c_ec_set: cover property ($rose(ec_state_reg));
endmodule

// ===== tb/bfp_afe_model.sv
/*
  behavioural analog front end of the protection controller: turns cell,
  load and charger conditions into the comparator levels the controller sees.
  assumes conditions are set by the bench just after a rising sys_clk edge.
*/
`timescale 1ns/100ps
module bfp_afe_model (
  input  wire logic cell_hi,
  input  wire logic cell_lo,
  input  wire logic load_oi,
  input  wire logic load_sc,
  input  wire logic chg_ec,
  input  wire logic chg_on,
  output logic      ovc_det_cmp,
  output logic      ovc_rel_cmp,
  output logic      ovd_det_cmp,
  output logic      ovd_rel_cmp,
  output logic      oi_det_cmp,
  output logic      oi_rel_cmp,
  output logic      sc_det_cmp,
  output logic      ec_det_cmp,
  output logic      sby_rel_cmp
);
  // no hysteresis band modelled: release follows detect as its inverse
  assign ovc_det_cmp = cell_hi;
  assign ovc_rel_cmp = !cell_hi;
  assign ovd_det_cmp = cell_lo;
  assign ovd_rel_cmp = !cell_lo;
  // a short always lifts the sense node past the over-current level too
  assign oi_det_cmp  = load_oi | load_sc;
  assign oi_rel_cmp  = !(load_oi | load_sc);
  assign sc_det_cmp  = load_sc;
  assign ec_det_cmp  = chg_ec;
  // any charger drags the sense node below the standby release level
  assign sby_rel_cmp = chg_on | chg_ec;
endmodule

// ===== tb/battery_fault_priority_ctrl_bench.sv
/*
  self-checking bench of the battery fault priority controller.
  assumes shortened delay parameters and the 1 us tick of the design.
*/
`timescale 1ns/100ps
`include "bfp_regs.svh"
module battery_fault_priority_ctrl_bench;
  localparam int TK = `BFP_TICK_CYC;
  localparam int OVC_D = 4, OVC_R = 2, OVD_D = 3, OVD_R = 2;
  localparam int OI_D = 5, OI_R = 2, EC_D = 2, EC_R = 2, SC_NS = 80;
  localparam int C = 0, D = 1, U = 2, N = 3, S = 4;
  logic        sys_clk = 1'b0, arst_n = 1'b0, test_shorten = 1'b0;
  logic        cell_hi = 1'b0, cell_lo = 1'b0, load_oi = 1'b0;
  logic        load_sc = 1'b0, chg_ec = 1'b0, chg_on = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
  logic        ovc_d, ovc_r, ovd_d, ovd_r, oi_d, oi_r, sc_d, ec_d, sby_r;
  logic        chg_gate, dis_gate, vm_pull_up, vm_pull_dn, standby;
  logic [4:0]  outs;
  int          err_count = 0, n_checks = 0;
  assign outs = {standby, vm_pull_dn, vm_pull_up, dis_gate, chg_gate};
  always #4 sys_clk = ~sys_clk;

  bfp_afe_model i_bfp_afe_model (.cell_hi(cell_hi), .cell_lo(cell_lo), .load_oi(load_oi),
    .load_sc(load_sc), .chg_ec(chg_ec), .chg_on(chg_on), .ovc_det_cmp(ovc_d),
    .ovc_rel_cmp(ovc_r), .ovd_det_cmp(ovd_d), .ovd_rel_cmp(ovd_r), .oi_det_cmp(oi_d),
    .oi_rel_cmp(oi_r), .sc_det_cmp(sc_d), .ec_det_cmp(ec_d), .sby_rel_cmp(sby_r));

  bfp_ctrl #(.OVC_DET_US(OVC_D), .OVC_REL_US(OVC_R), .OVD_DET_US(OVD_D),
    .OVD_REL_US(OVD_R), .OI_DET_US(OI_D), .OI_REL_US(OI_R), .EC_DET_US(EC_D),
    .EC_REL_US(EC_R), .SC_DLY_NS(SC_NS)) i_bfp_ctrl (.sys_clk(sys_clk), .arst_n(arst_n),
    .ovc_det_cmp(ovc_d), .ovc_rel_cmp(ovc_r), .ovd_det_cmp(ovd_d), .ovd_rel_cmp(ovd_r),
    .oi_det_cmp(oi_d), .oi_rel_cmp(oi_r), .sc_det_cmp(sc_d), .ec_det_cmp(ec_d),
    .sby_rel_cmp(sby_r), .test_shorten(test_shorten), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chg_gate(chg_gate), .dis_gate(dis_gate), .vm_pull_up(vm_pull_up),
    .vm_pull_dn(vm_pull_dn), .standby(standby));

  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the read edge
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic stat_bit(input string nm, input int b, input logic exp);
    reg_read(`BFP_STAT_OFS, rd);
    check(nm, 32'(rd[b]), 32'(exp));
  endtask

  // waits for one output to reach val and checks the elapsed cycles
  task automatic await(input string nm, input int sel, input logic val,
                       input int lo, input int hi);
    int n;
    n = 0;
    while (outs[sel] !== val && n <= hi) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check(nm, 32'(n >= lo && n <= hi), 32'h1);
  endtask

  // tick granularity leaves one tick of slack either way
  task automatic await_t(input string nm, input int sel, input logic val, input int k);
    await(nm, sel, val, k * TK - TK, k * TK + TK + 10);
  endtask

  task automatic restart();
    @(posedge sys_clk);
    {cell_hi, cell_lo, load_oi, load_sc, chg_ec, chg_on, test_shorten} <= 7'h0;
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset outputs", 32'(outs), 32'h03);
    reg_read(`BFP_CTRL_OFS, rd);
    check("ctrl reset", rd, 32'(`BFP_CTRL_RST));
    reg_read(`BFP_STAT_OFS, rd);
    check("status reset", rd, 32'h0);
    reg_write(8'h08, 32'hffff_ffff);
    reg_read(8'h08, rd);
    check("unmapped read", rd, 32'h0);
    // over-charge glitch must restart the count, then the full delay applies
    cell_hi <= 1'b1;
    repeat (3 * TK) @(posedge sys_clk);
    cell_hi <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cell_hi <= 1'b1;
    await_t("ovc full delay", C, 1'b0, OVC_D);
    check("dis during ovc", 32'(dis_gate), 32'h1);
    cell_hi <= 1'b0;
    await_t("ovc release", C, 1'b1, OVC_R);
    restart();
    test_shorten <= 1'b1;
    repeat (6) @(posedge sys_clk);
    stat_bit("shorten status", `BFP_ST_SHORT, 1'b1);
    cell_hi <= 1'b1;
    await("ovc shortened", C, 1'b0, 0, 2 * TK + 10);
    // short circuit inside over-charge state, both shorten levels
    for (int s = 0; s < 2; s++) begin
      restart();
      test_shorten <= s[0];
      cell_hi      <= 1'b1;
      await("ovc before short", C, 1'b0, 0, OVC_D * TK + TK + 10);
      load_sc <= 1'b1;
      await("short delay", D, 1'b0, 8, 24);
      stat_bit("short status", `BFP_ST_SC, 1'b1);
      load_sc <= 1'b0;
      await("short release", D, 1'b1, 0, OI_R * TK + TK + 10);
    end
    restart();
    load_oi <= 1'b1;
    await_t("oi delay", D, 1'b0, OI_D);
    check("oi pulls", 32'(outs[4:2]), 32'h2);
    cell_hi <= 1'b1;
    await_t("ovc after oi", C, 1'b0, OVC_D);
    check("oi first pull down", 32'(vm_pull_dn), 32'h1);
    restart();
    cell_hi <= 1'b1;
    await_t("ovc first", C, 1'b0, OVC_D);
    load_oi <= 1'b1;
    repeat ((OI_D + 2) * TK) @(posedge sys_clk);
    check("oi abandoned", 32'(outs[4:1]), 32'h1);
    stat_bit("oi status", `BFP_ST_OI, 1'b0);
    restart();
    cell_lo <= 1'b1;
    await_t("ovd delay", D, 1'b0, OVD_D);
    check("ovd pulls", 32'(outs[4:2]), 32'h5);
    load_oi <= 1'b1;
    repeat ((OI_D + 2) * TK) @(posedge sys_clk);
    stat_bit("oi after ovd", `BFP_ST_OI, 1'b0);
    load_oi <= 1'b0;
    chg_on  <= 1'b1;
    cell_lo <= 1'b0;
    await("standby left", S, 1'b0, 0, 20);
    await_t("ovd release", D, 1'b1, OVD_R);
    restart();
    load_oi <= 1'b1;
    await_t("oi before ovd", D, 1'b0, OI_D);
    cell_lo <= 1'b1;
    await_t("ovd after oi", S, 1'b1, OVD_D);
    @(posedge sys_clk);
    #1 check("pull swap", 32'(outs[3:2]), 32'h1);
    // both cell conditions at once: over-charge wins, over-discharge resumes
    restart();
    cell_hi <= 1'b1;
    cell_lo <= 1'b1;
    await_t("ovc wins", C, 1'b0, OVC_D);
    check("ovd held off", 32'(dis_gate), 32'h1);
    await_t("ovd resumed", D, 1'b0, OVD_D);
    check("no standby", 32'(outs[4:2]), 32'h1);
    restart();
    load_oi <= 1'b1;
    await_t("oi before ec", D, 1'b0, OI_D);
    chg_ec <= 1'b1;
    repeat ((EC_D + 2) * TK) @(posedge sys_clk);
    check("ec suppressed", 32'(chg_gate), 32'h1);
    load_oi <= 1'b0;
    await_t("dis back", D, 1'b1, OI_R);
    await_t("ec after dis", C, 1'b0, EC_D);
    chg_ec <= 1'b0;
    await_t("ec release", C, 1'b1, EC_R);
    // detection disable clears an established state
    restart();
    cell_hi <= 1'b1;
    await_t("ovc again", C, 1'b0, OVC_D);
    reg_write(`BFP_CTRL_OFS, 32'h0);
    repeat (4) @(posedge sys_clk);
    check("disable clears", 32'(chg_gate), 32'h1);
    reg_read(`BFP_STAT_OFS, rd);
    check("status cleared", rd, 32'h0);
    give_verdict();
  end
endmodule
